/* File: rtl/osd_i2c_port.v */
// Serial slave port of the display processor: bus protocol engine,
// 16 Kbyte internal space with display RAM, character ROM and registers.
// Assumes the bus pins are asynchronous and externally pulled up; the
// display engine reads RAM through its own port.
//
// Overview of operation
// - Answer only slave address bytes BA (write) and BB (read); ignore every other address.
// - Host writes reach the internal registers or the display RAM.
// - Write carries two internal address bytes, then any number of data.
// - Every byte moves most significant bit first.
// - Host may read registers, display RAM and character ROM.
// - Second read sequence has direction high; device then sends data.
// - Read bytes come from consecutive addresses from the latched one.
// - Registers, RAM and ROM share one 16 Kbyte internal space.
// - Sixteen host readable and writable registers program the display.
// - Host reaches the 1 Kbyte RAM while a page is displayed.
// - Screen refresh runs from memory with no host traffic.
// - Several pages in RAM; control register selects the shown one.
`timescale 1ns/10ps
`include "osd_port_regs.vh"

module osd_i2c_port #(
    parameter [7:0] ROM_SEED = 8'h5a
) (
    input  wire         mclk_i,
    input  wire         reset_n_i,
    input  wire         scl_i,
    input  wire         sda_i,
    output reg          sda_o,
    output reg          sda_oe_n_o,
    input  wire [9:0]   disp_addr_i,
    output reg  [7:0]   disp_data_o,
    output reg  [9:0]   page_base_o,
    output reg  [127:0] regs_o
);

    localparam ST_IDLE = 5'b00001;
    localparam ST_RX   = 5'b00010;
    localparam ST_ACK  = 5'b00100;
    localparam ST_TX   = 5'b01000;
    localparam ST_MACK = 5'b10000;

    localparam BUF_W = `INT_ADDR_W + 8;
    localparam [7:0] SLAVE_BYTE = `SLAVE_ADDR_BYTE;

    reg  [4:0]              state_r;
    reg  [1:0]              phase_r;
    reg  [2:0]              bitcnt_r;
    reg  [7:0]              shift_r;
    reg                     done_r;
    reg                     rw_r;
    reg  [`INT_ADDR_W-1:0]  addr_r;
    reg                     fetch_r;
    reg  [7:0]              rd_data_r;
    reg                     wr_valid_r;
    reg  [BUF_W-1:0]        wr_word_r;
    reg                     scl_d_r;
    reg                     sda_d_r;
    reg  [7:0]              ram_r [0:1023];

    wire                    scl_f;
    wire                    sda_f;
    wire                    scl_rise;
    wire                    scl_fall;
    wire                    bus_start;
    wire                    bus_stop;
    wire                    wr_in_ready;
    wire                    wr_out_valid;
    wire                    wr_out_ready;
    wire [BUF_W-1:0]        wr_out_word;
    wire [`INT_ADDR_W-1:0]  wr_addr;
    wire [7:0]              wr_byte;
    reg  [7:0]              rd_mux;

    pin_sync3 #(
        .RESET_LEVEL (1'b1)
    ) u_scl_sync (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (scl_i),
        .level_o   (scl_f)
    );

    pin_sync3 #(
        .RESET_LEVEL (1'b1)
    ) u_sda_sync (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (sda_i),
        .level_o   (sda_f)
    );

    // Bus conditions from filtered levels
    assign scl_rise  = scl_f & ~scl_d_r;
    assign scl_fall  = ~scl_f & scl_d_r;
    assign bus_start = scl_f & scl_d_r & sda_d_r & ~sda_f;
    assign bus_stop  = scl_f & scl_d_r & ~sda_d_r & sda_f;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_f;
            sda_d_r <= sda_f;
        end
    end

    // Protocol engine
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r    <= ST_IDLE;
            phase_r    <= `PH_SLAVE;
            bitcnt_r   <= 3'd0;
            shift_r    <= 8'h00;
            done_r     <= 1'b0;
            rw_r       <= 1'b0;
            addr_r     <= {`INT_ADDR_W{1'b0}};
            fetch_r    <= 1'b0;
            wr_valid_r <= 1'b0;
            wr_word_r  <= {BUF_W{1'b0}};
            sda_o      <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            fetch_r    <= 1'b0;
            wr_valid_r <= 1'b0;
            sda_o      <= 1'b0;
            if (bus_stop) begin
                state_r    <= ST_IDLE;
                sda_oe_n_o <= 1'b1;
            end else if (bus_start) begin
                state_r    <= ST_RX;
                phase_r    <= `PH_SLAVE;
                bitcnt_r   <= 3'd0;
                done_r     <= 1'b0;
                sda_oe_n_o <= 1'b1;
            end else begin
                case (state_r)
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_r  <= {shift_r[6:0], sda_f};
                            bitcnt_r <= bitcnt_r + 3'd1;
                            if (bitcnt_r == 3'd7) begin
                                done_r <= 1'b1;
                            end
                        end else if (scl_fall && done_r) begin
                            done_r <= 1'b0;
                            case (phase_r)
                                `PH_SLAVE: begin
                                    if (shift_r[7:1] == SLAVE_BYTE[7:1]) begin
                                        rw_r       <= shift_r[0];
                                        phase_r    <= `PH_ADDR_HI;
                                        state_r    <= ST_ACK;
                                        sda_oe_n_o <= 1'b0;
                                        fetch_r    <= shift_r[0];
                                    end else begin
                                        state_r <= ST_IDLE;
                                    end
                                end
                                `PH_ADDR_HI: begin
                                    addr_r[`INT_ADDR_W-1:8] <= shift_r[`INT_ADDR_W-9:0];
                                    phase_r    <= `PH_ADDR_LO;
                                    state_r    <= ST_ACK;
                                    sda_oe_n_o <= 1'b0;
                                end
                                `PH_ADDR_LO: begin
                                    addr_r[7:0] <= shift_r;
                                    phase_r     <= `PH_DATA;
                                    state_r     <= ST_ACK;
                                    sda_oe_n_o  <= 1'b0;
                                end
                                default: begin
                                    // A full buffer answers with a missing acknowledge
                                    if (wr_in_ready) begin
                                        wr_valid_r <= 1'b1;
                                        wr_word_r  <= {addr_r, shift_r};
                                        addr_r     <= addr_r + 1'b1;
                                        state_r    <= ST_ACK;
                                        sda_oe_n_o <= 1'b0;
                                    end else begin
                                        state_r <= ST_IDLE;
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bitcnt_r <= 3'd0;
                            if (rw_r) begin
                                state_r    <= ST_TX;
                                shift_r    <= rd_data_r;
                                addr_r     <= addr_r + 1'b1;
                                sda_oe_n_o <= rd_data_r[7];
                            end else begin
                                state_r    <= ST_RX;
                                sda_oe_n_o <= 1'b1;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_fall) begin
                            if (bitcnt_r == 3'd7) begin
                                state_r    <= ST_MACK;
                                sda_oe_n_o <= 1'b1;
                            end else begin
                                shift_r    <= {shift_r[6:0], 1'b0};
                                sda_oe_n_o <= shift_r[6];
                                bitcnt_r   <= bitcnt_r + 3'd1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            if (!sda_f) begin
                                fetch_r <= 1'b1;
                                done_r  <= 1'b1;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else if (scl_fall && done_r) begin
                            done_r     <= 1'b0;
                            bitcnt_r   <= 3'd0;
                            state_r    <= ST_TX;
                            shift_r    <= rd_data_r;
                            addr_r     <= addr_r + 1'b1;
                            sda_oe_n_o <= rd_data_r[7];
                        end
                    end
                    default: begin
                        sda_oe_n_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    word_buf2 #(
        .WIDTH (BUF_W)
    ) u_wr_buf (
        .mclk_i      (mclk_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (wr_valid_r),
        .in_ready_o  (wr_in_ready),
        .in_data_i   (wr_word_r),
        .out_valid_o (wr_out_valid),
        .out_ready_i (wr_out_ready),
        .out_data_o  (wr_out_word)
    );

    // Read fetches take the internal port first; writes wait a cycle
    assign wr_out_ready = ~fetch_r;
    assign wr_addr      = wr_out_word[BUF_W-1:8];
    assign wr_byte      = wr_out_word[7:0];

    // Read decode over the whole space; empty space reads zero
    always @* begin
        rd_mux = 8'h00;
        if (addr_r <= `RAM_LAST) begin
            rd_mux = ram_r[addr_r[9:0]];
        end else if (addr_r >= `ROM_BASE && addr_r <= `ROM_LAST) begin
            rd_mux = addr_r[7:0] ^ ROM_SEED;
        end else if (addr_r[`INT_ADDR_W-1:4] == `REG_PAGE) begin
            rd_mux = regs_o[addr_r[3:0]*8 +: 8];
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_r <= 8'h00;
        end else if (fetch_r) begin
            rd_data_r <= rd_mux;
        end
    end

    // Register file, one byte per entry
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi = gi + 1) begin : g_reg
            localparam [7:0] RST_VAL = (gi == 0) ? `REG_RST_0 :
                                       (gi == 1) ? `REG_RST_1 :
                                       (gi == 2) ? `REG_RST_2 :
                                       (gi == 3) ? `REG_RST_3 :
                                       (gi == 4) ? `REG_RST_4 :
                                       (gi == 5) ? `REG_RST_5 :
                                       (gi == 6) ? `REG_RST_6 :
                                       (gi == 7) ? `REG_RST_7 : `REG_RST_OTHER;
            always @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    regs_o[gi*8 +: 8] <= RST_VAL;
                end else if (wr_out_valid && wr_out_ready &&
                             wr_addr[`INT_ADDR_W-1:4] == `REG_PAGE &&
                             {28'h0000000, wr_addr[3:0]} == gi) begin
                    regs_o[gi*8 +: 8] <= wr_byte;
                end
            end
        end
    endgenerate

    // RAM write side; ROM and empty space drop writes
    always @(posedge mclk_i) begin
        if (wr_out_valid && wr_out_ready && wr_addr <= `RAM_LAST) begin
            ram_r[wr_addr[9:0]] <= wr_byte;
        end
    end

    // Display read port is separate, so host traffic never stalls refresh
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            disp_data_o <= 8'h00;
            page_base_o <= 10'h000;
        end else begin
            disp_data_o <= ram_r[disp_addr_i];
            page_base_o <= {7'h00, regs_o[`CTRL_REG_IDX*8 + `CTRL_PAGE_MSB -: 3]} << `PAGE_SHIFT;
        end
    end

endmodule // osd_i2c_port

/* File: rtl/osd_port_regs.vh */
// Constants of the serial memory access port: address map, slave address,
// register reset values and field positions.
// Assumes inclusion by bare name from the design files.
`ifndef OSD_PORT_REGS_VH
`define OSD_PORT_REGS_VH

// Slave address byte with the direction bit cleared
`define SLAVE_ADDR_BYTE    8'hba

// Internal address space, 14 bits wide
`define INT_ADDR_W         14
`define RAM_BASE           14'h0000
`define RAM_LAST           14'h03ff
`define ROM_BASE           14'h2000
`define ROM_LAST           14'h27ff
`define REG_PAGE           10'h3ff

// Register reset values, index 0 to 15
`define REG_RST_0          8'h3f
`define REG_RST_1          8'h08
`define REG_RST_2          8'h12
`define REG_RST_3          8'h00
`define REG_RST_4          8'h22
`define REG_RST_5          8'h33
`define REG_RST_6          8'h28
`define REG_RST_7          8'h0a
`define REG_RST_OTHER      8'h00

// Control register and its page field
`define CTRL_REG_IDX       4'h3
`define CTRL_PAGE_MSB      2
`define CTRL_PAGE_LSB      0
`define PAGE_SHIFT         6

// Byte phases within a transaction
`define PH_SLAVE           2'h0
`define PH_ADDR_HI         2'h1
`define PH_ADDR_LO         2'h2
`define PH_DATA            2'h3

`endif

/* File: rtl/pin_sync3.v */
// Three-stage input synchroniser with agreement filter for one pin.
// Assumes an asynchronous pin; the output changes once stages two and
// three agree.
`timescale 1ns/10ps

module pin_sync3 #(
    parameter RESET_LEVEL = 1'b1
) (
    input  wire mclk_i,
    input  wire reset_n_i,
    input  wire pin_i,
    output reg  level_o
);

    reg s1_r;
    reg s2_r;
    reg s3_r;

    // Stage one feeds stage two only
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_r    <= RESET_LEVEL;
            s2_r    <= RESET_LEVEL;
            s3_r    <= RESET_LEVEL;
            level_o <= RESET_LEVEL;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_o <= s3_r;
            end
        end
    end

endmodule // pin_sync3

/* File: rtl/word_buf2.v */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; full and empty are exact, so a stalled drain side
// pushes back on the source through in_ready_o.
`timescale 1ns/10ps

module word_buf2 #(
    parameter WIDTH = 22
) (
    input  wire             mclk_i,
    input  wire             reset_n_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem_r [0:1];
    reg             wr_ptr_r;
    reg             rd_ptr_r;
    reg [1:0]       count_r;
    wire            push;
    wire            pop;

    assign in_ready_o  = (count_r != 2'd2);
    assign out_valid_o = (count_r != 2'd0);
    assign out_data_o  = mem_r[rd_ptr_r];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push & ~pop) begin
                count_r <= count_r + 2'd1;
            end else if (pop & ~push) begin
                count_r <= count_r - 2'd1;
            end
        end
    end

    // Storage needs no reset; count guards it
    always @(posedge mclk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

endmodule // word_buf2

/* File: bench/osd_port_asserts.sv */
// Checker for the serial port top module: bus timing and outputs.
// Assumes SCL half periods of 64 clocks and a pulled-up data line.
`timescale 1ns/10ps
module osd_port_asserts (
    input wire         mclk_i,
    input wire         reset_n_i,
    input wire         scl_i,
    input wire         sda_i,
    input wire         sda_o,
    input wire         sda_oe_n_o,
    input wire [9:0]   disp_addr_i,
    input wire [7:0]   disp_data_o,
    input wire [9:0]   page_base_o,
    input wire [127:0] regs_o
);
    // A zero byte read out is the longest legal drive
    localparam int LOW_MAX = 1300;
    logic [10:0] low_cnt_r;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt_r <= 11'h000;
        end else begin
            low_cnt_r <= sda_oe_n_o ? 11'h000 : low_cnt_r + 11'h001;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    a_sda_drive_zero: assert property (sda_o == 1'b0)
        else $error("data drive value not zero");
    a_reset_values: assert property ($rose(reset_n_i) |->
        regs_o == 128'h0000_0000_0000_0000_0a28_3322_0012_083f && page_base_o == 10'h000 && sda_oe_n_o)
        else $error("register reset values wrong");
    a_page_map: assert property (page_base_o == {1'b0, $past(regs_o[26:24]), 6'h00})
        else $error("page base does not follow control register");
    a_oe_after_fall: assert property ($changed(sda_oe_n_o) |->
        !scl_i && !$past(scl_i, 2) && $past(scl_i, 8))
        else $error("data drive changed away from clock fall");
    a_scl_high_quiet: assert property (scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe_n_o))
        else $error("data drive changed while clock high");
    a_start_no_drive: assert property ($fell(sda_i) && scl_i |-> sda_oe_n_o)
        else $error("device drives during start");
    a_oe_low_bound: assert property (low_cnt_r < LOW_MAX)
        else $error("data line held low too long");
    a_disp_stable: assert property (scl_i && $past(scl_i, 8) && $past(reset_n_i, 2) && $stable(disp_addr_i)
        |=> $stable(disp_data_o))
        else $error("display data changed without a write");
endmodule // osd_port_asserts

bind osd_i2c_port osd_port_asserts u_chk (
    .mclk_i      (mclk_i),
    .reset_n_i   (reset_n_i),
    .scl_i       (scl_i),
    .sda_i       (sda_i),
    .sda_o       (sda_o),
    .sda_oe_n_o  (sda_oe_n_o),
    .disp_addr_i (disp_addr_i),
    .disp_data_o (disp_data_o),
    .page_base_o (page_base_o),
    .regs_o      (regs_o)
);

/* File: bench/i2c_master_model.sv */
// Bus master model: serial clock and open-drain data release.
// Assumes the bench resolves the wire from both drivers and a pull-up.
`timescale 1ns/10ps
module i2c_master_model #(
    parameter int HALF = 64
) (
    input  wire  mclk_i,
    input  wire  sda_i,
    output logic scl_o,
    output logic sda_rel_o
);
    initial begin
        scl_o = 1'b1;
        sda_rel_o = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // Level set early in the low phase for setup margin
    task automatic bit_cycle(input logic b, output logic v);
        sda_rel_o <= b;
        wait_clk(HALF - 8);
        scl_o <= 1'b1;
        wait_clk(HALF);
        v = sda_i;
        scl_o <= 1'b0;
        wait_clk(8);
    endtask
    task automatic start;
        sda_rel_o <= 1'b1;
        wait_clk(8);
        scl_o <= 1'b1;
        wait_clk(HALF);
        sda_rel_o <= 1'b0;
        wait_clk(HALF);
        scl_o <= 1'b0;
        wait_clk(8);
    endtask
    task automatic stop;
        sda_rel_o <= 1'b0;
        wait_clk(HALF - 8);
        scl_o <= 1'b1;
        wait_clk(HALF);
        sda_rel_o <= 1'b1;
        wait_clk(HALF);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], v);
        end
        bit_cycle(1'b1, v);
        ack = !v;
    endtask
    task automatic recv_byte(input logic m_ack, output logic [7:0] d);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(!m_ack, v);
    endtask
endmodule // i2c_master_model

/* File: bench/tb_top.sv */
// Self-checking bench for the serial memory access port.
// Assumes checker and master model are compiled first.
`timescale 1ns/10ps
module tb_top;
    localparam logic [7:0] ROM_SEED = 8'h5a;
    logic         mclk_i;
    logic         reset_n_i;
    logic [9:0]   disp_addr_i;
    wire          scl_w;
    wire          m_rel;
    wire          sda_o;
    wire          sda_oe_n_o;
    wire  [7:0]   disp_data_o;
    wire  [9:0]   page_base_o;
    wire  [127:0] regs_o;
    wire          sda_w;
    int           errors;
    int           n_checks;
    logic [7:0]   wdat [0:7];
    logic [7:0]   rdat [0:7];
    logic         ack;
    // Pull-up wins unless either side pulls low
    assign sda_w = m_rel & (sda_oe_n_o ? 1'b1 : sda_o);
    osd_i2c_port #(.ROM_SEED(ROM_SEED)) dut (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n_o(sda_oe_n_o), .disp_addr_i(disp_addr_i), .disp_data_o(disp_data_o),
        .page_base_o(page_base_o), .regs_o(regs_o));
    i2c_master_model #(.HALF(64)) m (.mclk_i(mclk_i), .sda_i(sda_w), .scl_o(scl_w), .sda_rel_o(m_rel));
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end
    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic send_addr(input logic [13:0] a);
        m.start();
        m.send_byte(8'hba, ack);
        chk("slave ack", 1'b1, ack);
        m.send_byte({2'b00, a[13:8]}, ack);
        chk("addr hi ack", 1'b1, ack);
        m.send_byte(a[7:0], ack);
        chk("addr lo ack", 1'b1, ack);
    endtask
    task automatic wr_seq(input logic [13:0] a, input int n);
        send_addr(a);
        for (int i = 0; i < n; i++) begin
            m.send_byte(wdat[i], ack);
            chk("data ack", 1'b1, ack);
        end
        m.stop();
    endtask
    task automatic rd_seq(input logic [13:0] a, input int n);
        send_addr(a);
        m.start();
        m.send_byte(8'hbb, ack);
        chk("read slave ack", 1'b1, ack);
        for (int i = 0; i < n; i++) begin
            m.recv_byte(i != n - 1, rdat[i]);
        end
        m.stop();
    endtask
    task automatic t_reset_vals;
        chk("regs_o", 128'h0000_0000_0000_0000_0a28_3322_0012_083f, regs_o);
        chk("page_base_o", 10'h000, page_base_o);
    endtask
    // Burst runs off the end of RAM into empty space
    task automatic t_ram_burst;
        wdat[0] = 8'ha5;
        wdat[1] = 8'h3c;
        wdat[2] = 8'h77;
        wr_seq(14'h03fe, 3);
        rd_seq(14'h03fe, 3);
        chk("ram 3fe", 8'ha5, rdat[0]);
        chk("ram 3ff", 8'h3c, rdat[1]);
        chk("empty 400", 8'h00, rdat[2]);
        @(posedge mclk_i);
        disp_addr_i <= 10'h3ff;
        repeat (3) @(posedge mclk_i);
        chk("disp_data_o", 8'h3c, disp_data_o);
    endtask
    task automatic t_page_select;
        wdat[0] = 8'h05;
        wr_seq(14'h3ff3, 1);
        chk("ctrl reg", 8'h05, regs_o[31:24]);
        chk("page_base_o", 10'h140, page_base_o);
        rd_seq(14'h3ff2, 2);
        chk("reg 2", 8'h12, rdat[0]);
        chk("reg 3", 8'h05, rdat[1]);
    endtask
    task automatic t_rom_read;
        rd_seq(14'h2000, 2);
        chk("rom 2000", 8'h00 ^ ROM_SEED, rdat[0]);
        chk("rom 2001", 8'h01 ^ ROM_SEED, rdat[1]);
    endtask
    // Bytes after a foreign address must be ignored until the next start
    task automatic t_foreign;
        m.start();
        m.send_byte(8'hb8, ack);
        chk("foreign ack", 1'b0, ack);
        m.send_byte(8'h3f, ack);
        m.send_byte(8'hf3, ack);
        m.send_byte(8'h07, ack);
        chk("foreign data ack", 1'b0, ack);
        m.stop();
        chk("ctrl kept", 8'h05, regs_o[31:24]);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        errors = 0;
        n_checks = 0;
        reset_n_i = 1'b0;
        disp_addr_i = 10'h000;
        repeat (4) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        t_reset_vals();
        t_ram_burst();
        t_page_select();
        t_rom_read();
        t_foreign();
        finish_test();
    end
    // About 40k cycles of traffic expected
    initial begin
        repeat (80000) @(posedge mclk_i);
        errors++;
        $display("mismatch watchdog expected done seen timeout");
        finish_test();
    end
endmodule // tb_top
